// *** host_chan_pkg.sv ***
package host_chan_pkg;

  // APB word index of each register; byte address is index * 4
  localparam int          ADDR_W       = 12;
  localparam logic [9:0]  CH0_STAT_IDX = 10'h145;
  localparam logic [9:0]  CHA_STAT_IDX = 10'h146;
  localparam logic [9:0]  CTL_CTRL_IDX = 10'h150;
  localparam logic [9:0]  MS_CTRL_IDX  = 10'h151;
  localparam logic [9:0]  CFG0_IDX     = 10'h152;
  localparam logic [9:0]  CH0_MASK_IDX = 10'h153;
  localparam logic [9:0]  CHA_MASK_IDX = 10'h154;
  localparam logic [9:0]  COND_IDX     = 10'h155;

  // Status field positions
  localparam int TOTAL_BIT     = 7;
  localparam int ACK_BIT       = 6;
  localparam int TERR_BIT      = 5;
  localparam int COND_BIT      = 4;
  localparam int SEQ_DONE_BIT  = 1;
  localparam int SEQ_ABORT_BIT = 0;
  localparam int CTL_ABORT_BIT = 0;

  // Control field positions
  localparam int RUN_BIT     = 0;
  localparam int CFG_RUN_BIT = 7;
  localparam int ACK_CNT_LSB = 0;
  localparam int ACK_CNT_W   = 4;

  // Reset values and implemented-bit masks
  localparam logic [7:0] STAT_RESET    = 8'h00;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CHA_IMPL_MASK = 8'hF3;
  localparam logic [7:0] CH0_IMPL_MASK = 8'h01;

  localparam logic [1:0] RETRY_LIMIT = 2'h3;

  typedef enum logic [2:0] {
    COND_NO_ERROR  = 3'h0,
    COND_STALL     = 3'h1,
    COND_OVERRUN   = 3'h2,
    COND_UNDERRUN  = 3'h3,
    COND_RETRY     = 3'h4
  } cond_t;

  // One finished transaction as reported by the packet engine
  typedef struct packed {
    logic done;
    logic ack_ok;
    logic timeout;
    logic crc_err;
    logic stuff_err;
    logic pid_err;
    logic toggle_err;
    logic stall;
    logic over_max_pkt;
    logic over_irp;
    logic short_pkt;
    logic under_irp;
  } txn_result_t;

  // Transport-level events of the running sequencer
  typedef struct packed {
    logic phase_done;
    logic phase_err;
    logic stop_done;
    logic stop_ok;
  } seq_event_t;

endpackage

// *** host_channel_int_status.sv ***
// Notes on behaviour
// - Control sequencer ending a transfer early on error sets control abort.
// - After control run cleared, stop outside status stage or status error aborts.
// - Channel A status at index 146h; writing one clears a flag.
// - Bit 7 set when the programmed IRP transfer completes cleanly.
// - With mass-storage sequencer, bit 7 only after all three phases succeed or a stop in status phase ends cleanly.
// - Bit 6 set once the programmed ACK count of transactions succeeded.
// - With mass-storage sequencer, bit 6 only during the data phase.
// - Bit 5 set on any retry-class transaction error.
// - Bit 4 on three consecutive retries, stall, overrun or underrun.
// - Firmware clearing transfer run sets bit 4; code shows last result.
// - Condition code: 0 ok, 1 stall, 2 overrun, 3 underrun, 4 retry.
// - Overrun on oversize packet or IRP; CRC/stuff or short-toggle wins.
// - Underrun on short final packet unless CRC or stuff error coincides.
// - Timeout, CRC, stuff, PID check, bad PID, toggle count as retry.
// - Bit 1 set when mass-storage status phase finishes cleanly.
// - After run cleared, bit 1 set if status phase ends cleanly on stop.
// - Bit 0 set when any mass-storage phase ends with an error.
// - After run cleared, stop outside status phase or status error aborts.
// - Summary interrupt high while a set flag has its mask bit enabled.
module host_channel_int_status
  import host_chan_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Channel A packet engine
  input  wire txn_result_t       txn,
  input  wire logic              irp_done,
  // Mass-storage transport events
  input  wire seq_event_t        ms_evt,
  // Control-transfer sequencer events
  input  wire logic              ctl_err,
  input  wire logic              ctl_stop_done,
  input  wire logic              ctl_stop_in_status,
  input  wire logic              ctl_status_ok,
  // Run controls toward the engines
  output logic                   channel_transfer_run,
  output logic                   mass_storage_seq_run,
  output logic                   control_seq_run,
  output logic [2:0]             mass_storage_phase,
  // Summary interrupts
  output logic                   int_ch0,
  output logic                   int_cha
);

  typedef enum logic [4:0] {
    MS_IDLE = 5'b00001,
    MS_CBW  = 5'b00010,
    MS_DATA = 5'b00100,
    MS_CSW  = 5'b01000,
    MS_STOP = 5'b10000
  } ms_state_t;

  ms_state_t             ms_state_reg;
  ms_state_t             ms_state_next;
  logic [7:0]            cha_stat_reg;
  logic [7:0]            ch0_stat_reg;
  logic [7:0]            cha_mask_reg;
  logic [7:0]            ch0_mask_reg;
  logic [7:0]            cfg0_reg;
  logic                  ms_run_reg;
  logic                  ctl_run_reg;
  logic                  ctl_stopping_reg;
  logic                  stop_in_csw_reg;
  cond_t                 cond_reg;
  logic [1:0]            retry_cnt_reg;
  logic [ACK_CNT_W-1:0]  ack_cnt_reg;
  logic [31:0]           prdata_reg;
  logic                  pslverr_reg;

  logic [9:0]            idx;
  logic                  wr_en;
  logic                  setup;
  logic                  mapped;
  logic                  wr_cha;
  logic                  wr_ch0;
  logic                  wr_cfg0;
  logic                  wr_ms;
  logic                  wr_ctl;
  logic [7:0]            cha_clr;
  logic [7:0]            ch0_clr;
  logic [7:0]            cha_set;
  logic [7:0]            ch0_set;
  logic                  is_retry;
  cond_t                 txn_cond;
  logic                  three_retries;
  logic                  ack_reached;
  logic                  fw_xfer_stop;
  logic                  ms_active;
  logic                  ms_seq_done;
  logic                  ms_seq_abort;
  logic                  ms_run_drop;
  logic                  ctl_abort;
  logic [ACK_CNT_W-1:0]  ack_target;

  // Bus decode; zero wait states, so pready stays high
  assign idx     = paddr[11:2];
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & pstrb[0];
  assign wr_cha  = wr_en & (idx == CHA_STAT_IDX);
  assign wr_ch0  = wr_en & (idx == CH0_STAT_IDX);
  assign wr_cfg0 = wr_en & (idx == CFG0_IDX);
  assign wr_ms   = wr_en & (idx == MS_CTRL_IDX);
  assign wr_ctl  = wr_en & (idx == CTL_CTRL_IDX);

  always_comb begin
    case (idx)
      CH0_STAT_IDX, CHA_STAT_IDX, CTL_CTRL_IDX, MS_CTRL_IDX,
      CFG0_IDX, CH0_MASK_IDX, CHA_MASK_IDX, COND_IDX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Only ones clear, and only implemented flags
  assign cha_clr = wr_cha ? (pwdata[7:0] & CHA_IMPL_MASK) : 8'h00;
  assign ch0_clr = wr_ch0 ? (pwdata[7:0] & CH0_IMPL_MASK) : 8'h00;

  // Transaction classification; CRC/stuff dominates size errors
  assign is_retry = txn.timeout | txn.crc_err | txn.stuff_err
                  | txn.pid_err | txn.toggle_err;

  always_comb begin
    if (is_retry) begin
      txn_cond = COND_RETRY;
    end else if (txn.stall) begin
      txn_cond = COND_STALL;
    end else if (txn.over_max_pkt | txn.over_irp) begin
      txn_cond = COND_OVERRUN;
    end else if (txn.short_pkt & txn.under_irp) begin
      txn_cond = COND_UNDERRUN;
    end else begin
      txn_cond = COND_NO_ERROR;
    end
  end

  assign three_retries = txn.done & is_retry
                       & (retry_cnt_reg == RETRY_LIMIT - 2'h1);

  assign ack_target  = cfg0_reg[ACK_CNT_LSB +: ACK_CNT_W];
  // A zero count never fires, which avoids a flag on every 16th ACK
  assign ack_reached = txn.done & txn.ack_ok & ~is_retry
                     & (ack_target != '0)
                     & (ack_cnt_reg + 1'b1 == ack_target);

  assign fw_xfer_stop = wr_cfg0 & cfg0_reg[CFG_RUN_BIT]
                      & ~pwdata[CFG_RUN_BIT];

  assign ms_active = (ms_state_reg != MS_IDLE);

  // Mass-storage sequencer outcome
  always_comb begin
    ms_seq_done  = 1'b0;
    ms_seq_abort = 1'b0;
    case (ms_state_reg)
      MS_CBW, MS_DATA: begin
        ms_seq_abort = ms_evt.phase_err;
      end
      MS_CSW: begin
        ms_seq_done  = ms_evt.phase_done & ~ms_evt.phase_err;
        ms_seq_abort = ms_evt.phase_err;
      end
      MS_STOP: begin
        ms_seq_done  = ms_evt.stop_done & stop_in_csw_reg
                     & ms_evt.stop_ok;
        ms_seq_abort = ms_evt.stop_done
                     & ~(stop_in_csw_reg & ms_evt.stop_ok);
      end
      default: begin
        ms_seq_done  = 1'b0;
        ms_seq_abort = 1'b0;
      end
    endcase
  end

  assign ms_run_drop = wr_ms & ms_run_reg & ~pwdata[RUN_BIT];

  always_comb begin
    ms_state_next = ms_state_reg;
    case (ms_state_reg)
      MS_IDLE: begin
        if (ms_run_reg) begin
          ms_state_next = MS_CBW;
        end
      end
      MS_CBW, MS_DATA, MS_CSW: begin
        if (ms_run_drop) begin
          ms_state_next = MS_STOP;
        end else if (ms_evt.phase_err | ms_seq_done) begin
          ms_state_next = MS_IDLE;
        end else if (ms_evt.phase_done) begin
          ms_state_next = (ms_state_reg == MS_CBW) ? MS_DATA : MS_CSW;
        end
      end
      MS_STOP: begin
        if (ms_evt.stop_done) begin
          ms_state_next = MS_IDLE;
        end
      end
      default: ms_state_next = MS_IDLE;
    endcase
  end

  // Control sequencer abort causes
  assign ctl_abort = (ctl_err & ctl_run_reg)
                   | (ctl_stopping_reg & ctl_stop_done
                      & (~ctl_stop_in_status | ~ctl_status_ok));

  // Flag set terms
  always_comb begin
    cha_set = 8'h00;
    cha_set[TOTAL_BIT] = ms_active ? ms_seq_done : irp_done;
    cha_set[ACK_BIT]   = ack_reached
                       & (~ms_active | ms_state_reg == MS_DATA);
    cha_set[TERR_BIT]  = txn.done & is_retry;
    cha_set[COND_BIT]  = three_retries
                       | (txn.done & (txn_cond == COND_STALL
                          | txn_cond == COND_OVERRUN
                          | txn_cond == COND_UNDERRUN))
                       | fw_xfer_stop;
    cha_set[SEQ_DONE_BIT]  = ms_seq_done;
    cha_set[SEQ_ABORT_BIT] = ms_seq_abort;
    ch0_set = 8'h00;
    ch0_set[CTL_ABORT_BIT] = ctl_abort;
  end

  // Status flags: a set in the clearing cycle wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cha_stat_reg <= STAT_RESET;
    end else begin
      cha_stat_reg <= ((cha_stat_reg & ~cha_clr) | cha_set)
                    & CHA_IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ch0_stat_reg <= STAT_RESET;
    end else begin
      ch0_stat_reg <= ((ch0_stat_reg & ~ch0_clr) | ch0_set)
                    & CH0_IMPL_MASK;
    end
  end

  // Mask and configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cha_mask_reg <= CTRL_RESET;
      ch0_mask_reg <= CTRL_RESET;
      cfg0_reg     <= CTRL_RESET;
    end else begin
      if (wr_en & (idx == CHA_MASK_IDX)) begin
        cha_mask_reg <= pwdata[7:0] & CHA_IMPL_MASK;
      end
      if (wr_en & (idx == CH0_MASK_IDX)) begin
        ch0_mask_reg <= pwdata[7:0] & CH0_IMPL_MASK;
      end
      if (wr_cfg0) begin
        cfg0_reg <= pwdata[7:0];
      end
    end
  end

  // Mass-storage run bit; hardware drops it when the sequence ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_run_reg <= 1'b0;
    end else if (wr_ms) begin
      ms_run_reg <= pwdata[RUN_BIT];
    end else if (ms_seq_done | ms_seq_abort) begin
      ms_run_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_state_reg    <= MS_IDLE;
      stop_in_csw_reg <= 1'b0;
    end else begin
      ms_state_reg <= ms_state_next;
      if (ms_run_drop & ms_active) begin
        stop_in_csw_reg <= (ms_state_reg == MS_CSW);
      end
    end
  end

  // Control sequencer run and stop tracking
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_run_reg      <= 1'b0;
      ctl_stopping_reg <= 1'b0;
    end else begin
      if (wr_ctl) begin
        ctl_run_reg <= pwdata[RUN_BIT];
      end else if (ctl_err) begin
        ctl_run_reg <= 1'b0;
      end
      if (wr_ctl & ctl_run_reg & ~pwdata[RUN_BIT]) begin
        ctl_stopping_reg <= 1'b1;
      end else if (ctl_stop_done) begin
        ctl_stopping_reg <= 1'b0;
      end
    end
  end

  // Last transaction result and retry run length
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cond_reg      <= COND_NO_ERROR;
      retry_cnt_reg <= 2'h0;
    end else if (txn.done) begin
      cond_reg <= txn_cond;
      if (!is_retry || three_retries) begin
        retry_cnt_reg <= 2'h0;
      end else begin
        retry_cnt_reg <= retry_cnt_reg + 2'h1;
      end
    end
  end

  // Successful-transaction count toward the ACK target
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_cnt_reg <= '0;
    end else if (fw_xfer_stop | ack_reached) begin
      ack_cnt_reg <= '0;
    end else if (txn.done & txn.ack_ok & ~is_retry) begin
      ack_cnt_reg <= ack_cnt_reg + 1'b1;
    end
  end

  // Read data captured in setup so it is stable through access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      pslverr_reg <= ~mapped;
      case (idx)
        CHA_STAT_IDX: prdata_reg <= {24'h000000, cha_stat_reg};
        CH0_STAT_IDX: prdata_reg <= {24'h000000, ch0_stat_reg};
        CHA_MASK_IDX: prdata_reg <= {24'h000000, cha_mask_reg};
        CH0_MASK_IDX: prdata_reg <= {24'h000000, ch0_mask_reg};
        CFG0_IDX:     prdata_reg <= {24'h000000, cfg0_reg};
        MS_CTRL_IDX:  prdata_reg <= {31'h00000000, ms_run_reg};
        CTL_CTRL_IDX: prdata_reg <= {31'h00000000, ctl_run_reg};
        COND_IDX:     prdata_reg <= {29'h00000000, cond_reg};
        default:      prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready  = 1'b1;

  // Outputs toward engines
  assign channel_transfer_run = cfg0_reg[CFG_RUN_BIT];
  assign mass_storage_seq_run = ms_run_reg;
  assign control_seq_run      = ctl_run_reg;

  always_comb begin
    case (ms_state_reg)
      MS_CBW:  mass_storage_phase = 3'h1;
      MS_DATA: mass_storage_phase = 3'h2;
      MS_CSW:  mass_storage_phase = 3'h4;
      default: mass_storage_phase = 3'h0;
    endcase
  end

  // Summary interrupts
  assign int_cha = |(cha_stat_reg & cha_mask_reg);
  assign int_ch0 = |(ch0_stat_reg & ch0_mask_reg);

endmodule

// *** host_chan_assertions.sv ***
module host_chan_checker
  import host_chan_pkg::*;
(
  // Clock, reset and bus
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Sequencer side
  input wire logic              ctl_err,
  input wire seq_event_t        ms_evt,
  input wire logic              channel_transfer_run,
  input wire logic              mass_storage_seq_run,
  input wire logic              control_seq_run,
  input wire logic [2:0]        mass_storage_phase,
  input wire logic              int_ch0,
  input wire logic              int_cha
);
  logic [9:0] idx;
  logic       setup;
  logic       wr;
  logic       mapped;
  logic       mask_seen;
  assign idx    = paddr[11:2];
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite && pstrb[0];
  assign mapped = idx == CH0_STAT_IDX || idx == CHA_STAT_IDX || (idx >= CTL_CTRL_IDX && idx <= COND_IDX);
  // No interrupt can be open before software writes a mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_seen <= 1'b0;
    end else if (wr && (idx == CH0_MASK_IDX || idx == CHA_MASK_IDX)) begin
      mask_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ready_high_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (setup && !mapped |=> pslverr) else $error("unmapped not refused");
  good_addr_a: assert property (setup && mapped |=> !pslverr) else $error("mapped refused");
  reserved_zero_a: assert property (setup && !pwrite && idx == CHA_STAT_IDX |=>
    prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0) else $error("reserved bits set");
  run_follow_a: assert property (wr && idx == CFG0_IDX |=>
    channel_transfer_run == $past(pwdata[CFG_RUN_BIT])) else $error("transfer run wrong");
  ctl_err_stop_a: assert property (control_seq_run && ctl_err |=> !control_seq_run)
    else $error("control run kept after error");
  ms_err_idle_a: assert property (mass_storage_phase != 3'h0 && ms_evt.phase_err |=>
    mass_storage_phase == 3'h0 && !mass_storage_seq_run) else $error("sequencer not idle after error");
  ms_start_a: assert property (wr && idx == MS_CTRL_IDX && pwdata[RUN_BIT] && !mass_storage_seq_run
    |-> ##[1:2] mass_storage_phase == 3'h1) else $error("command phase not entered");
  phase_hot_a: assert property ($onehot0(mass_storage_phase)) else $error("phase not one-hot");
  int_closed_a: assert property (!mask_seen |-> !int_cha && !int_ch0) else $error("interrupt unmasked");
endmodule
bind host_channel_int_status host_chan_checker i_host_chan_checker (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ctl_err(ctl_err), .ms_evt(ms_evt),
  .channel_transfer_run(channel_transfer_run), .mass_storage_seq_run(mass_storage_seq_run),
  .control_seq_run(control_seq_run), .mass_storage_phase(mass_storage_phase), .int_ch0(int_ch0),
  .int_cha(int_cha));

// *** usb_dev_model.sv ***
module usb_dev_model
  import host_chan_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] kind,
  input  wire logic [2:0] lag,
  output txn_result_t     txn
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic txn_result_t reply(input logic [3:0] k);
    txn_result_t r;
    r = '0;
    r.done = 1'b1;
    case (k)
      4'h0: r.ack_ok = 1'b1;
      4'h1: r.timeout = 1'b1;
      4'h2: r.crc_err = 1'b1;
      4'h3: r.stuff_err = 1'b1;
      4'h4: r.pid_err = 1'b1;
      4'h5: r.toggle_err = 1'b1;
      4'h6: r.stall = 1'b1;
      4'h7: r.over_max_pkt = 1'b1;
      4'h8: {r.short_pkt, r.under_irp} = 2'h3;
      default: {r.crc_err, r.over_irp} = 2'h3;
    endcase
    return r;
  endfunction
  initial txn = '0;
  // Qualifiers are junk outside the done pulse, never a stale answer
  always @(posedge clk) begin
    if (go) begin
      repeat (lag) @(posedge clk);
      txn <= reply(kind);
      @(posedge clk);
      txn <= {1'b0, 11'($urandom)};
    end
  end
endmodule

// *** tb_top.sv ***
module tb_top
  import host_chan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, exp_q[$];
  logic [3:0]        pstrb, kind;
  logic [5:0]        pv;
  logic [2:0]        lag, msph;
  logic              go, msok, c_in, c_ok, ctr, msr, clr, ich0, icha;
  txn_result_t       txn;
  int                err_total, n_checks, n;

  host_channel_int_status i_host_channel_int_status (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txn(txn), .irp_done(pv[0]), .ms_evt({pv[1], pv[2], pv[3], msok}),
    .ctl_err(pv[4]), .ctl_stop_done(pv[5]), .ctl_stop_in_status(c_in), .ctl_status_ok(c_ok),
    .channel_transfer_run(ctr), .mass_storage_seq_run(msr), .control_seq_run(clr),
    .mass_storage_phase(msph), .int_ch0(ich0), .int_cha(icha));
  usb_dev_model i_usb_dev_model (.clk(clk), .go(go), .kind(kind), .lag(lag), .txn(txn));

  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [9:0] i, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(i, 1'b1, {24'h0, d});
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    apb(i, 1'b0, 32'h0);
  endtask
  task automatic pulse(input int s);
    @(posedge clk);
    pv <= 6'h01 << s;
    @(posedge clk);
    pv <= 6'h00;
  endtask
  task automatic send(input logic [3:0] k);
    @(posedge clk);
    kind <= k;
    lag <= 3'($urandom_range(0, 4));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (txn.done !== 1'b1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Read results checked in the cycle the access phase completes
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk($sformatf("read %h", paddr), exp_q.pop_front(), prdata);
  end
  initial begin
    #200000;
    err_total++;
    results();
  end

  initial begin
    {clk, reset_n, psel, penable, pwrite, go, msok, c_in, c_ok} = '0;
    {paddr, pwdata, pstrb, kind, lag, pv} = '0;
    {err_total, n_checks} = '0;
    void'($urandom(69496));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 'h145; i <= 'h156; i++) rd(10'(i), 8'h00);
    $display("reset values done");
    for (int k = 1; k <= 5; k++) begin
      send(4'(k));
      rd(CHA_STAT_IDX, k >= 3 ? 8'h30 : 8'h20);
      wr(CHA_STAT_IDX, 8'h20);
    end
    rd(COND_IDX, 8'h04);
    wr(CHA_STAT_IDX, 8'h10);
    rd(CHA_STAT_IDX, 8'h00);
    send(4'h0);
    // Stopping a run restarts the ACK count left over from earlier transactions
    wr(CFG0_IDX, 8'h80);
    wr(CFG0_IDX, 8'h00);
    for (int k = 6; k <= 9; k++) begin
      send(4'(k));
      rd(COND_IDX, k == 9 ? 8'h04 : 8'(k - 5));
      wr(CHA_STAT_IDX, 8'h00);
      rd(CHA_STAT_IDX, k == 9 ? 8'h20 : 8'h10);
      wr(CHA_STAT_IDX, 8'hFF);
    end
    $display("condition codes done");
    n = $urandom_range(1, 15);
    wr(CFG0_IDX, 8'h80 | 8'(n));
    repeat (n - 1) send(4'h0);
    rd(CHA_STAT_IDX, 8'h00);
    send(4'h0);
    rd(CHA_STAT_IDX, 8'h40);
    wr(CHA_STAT_IDX, 8'h40);
    wr(CFG0_IDX, 8'h00);
    rd(CHA_STAT_IDX, 8'h10);
    rd(COND_IDX, 8'h00);
    wr(CHA_STAT_IDX, 8'h10);
    wr(CHA_MASK_IDX, 8'h80);
    pulse(0);
    rd(CHA_STAT_IDX, 8'h80);
    #1;
    chk("int_cha", 32'h1, {31'h0, icha});
    wr(CHA_STAT_IDX, 8'h80);
    #1;
    chk("int_cha", 32'h0, {31'h0, icha});
    $display("ack count and irp done");
    wr(CFG0_IDX, 8'h01);
    wr(MS_CTRL_IDX, 8'h01);
    send(4'h0);
    rd(CHA_STAT_IDX, 8'h00);
    pulse(1);
    send(4'h0);
    rd(CHA_STAT_IDX, 8'h40);
    pulse(1);
    pulse(1);
    rd(CHA_STAT_IDX, 8'hC2);
    rd(MS_CTRL_IDX, 8'h00);
    wr(CHA_STAT_IDX, 8'hFF);
    wr(MS_CTRL_IDX, 8'h01);
    pulse(1);
    pulse(2);
    rd(CHA_STAT_IDX, 8'h01);
    rd(MS_CTRL_IDX, 8'h00);
    wr(CHA_STAT_IDX, 8'h01);
    for (int k = 0; k < 3; k++) begin
      msok <= k == 0;
      wr(MS_CTRL_IDX, 8'h01);
      repeat (k < 2 ? 2 : 0) pulse(1);
      wr(MS_CTRL_IDX, 8'h00);
      pulse(3);
      rd(CHA_STAT_IDX, k == 0 ? 8'h82 : 8'h01);
      wr(CHA_STAT_IDX, 8'h83);
    end
    $display("mass storage done");
    wr(CH0_MASK_IDX, 8'h01);
    wr(CTL_CTRL_IDX, 8'h01);
    pulse(4);
    rd(CH0_STAT_IDX, 8'h01);
    rd(CTL_CTRL_IDX, 8'h00);
    #1;
    chk("int_ch0", 32'h1, {31'h0, ich0});
    wr(CH0_STAT_IDX, 8'h01);
    for (int k = 0; k < 3; k++) begin
      c_in <= k < 2;
      c_ok <= k != 1;
      wr(CTL_CTRL_IDX, 8'h01);
      wr(CTL_CTRL_IDX, 8'h00);
      pulse(5);
      rd(CH0_STAT_IDX, k == 0 ? 8'h00 : 8'h01);
      wr(CH0_STAT_IDX, 8'h01);
    end
    $display("control sequencer done");
    results();
  end
endmodule
